//--- src/cbb_cfg_regs.sv
`timescale 1ns/1ps
module cbb_cfg_regs (
  // Clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  // Configuration access
  input wire cbb_pkg::cbb_cfg_req_t cfg_req_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  // Memory window decode
  input wire logic mem_valid_in,
  input wire logic [31:0] mem_addr_in,
  output cbb_pkg::cbb_win_t win_out,
  output logic [31:0] base_addr_out,
  // Secondary bus events and enables
  input wire cbb_pkg::cbb_evt_t evt_in,
  input wire cbb_pkg::cbb_en_t en_in,
  input wire logic cserr_n_in,
  // Host system error, open drain
  output logic serr_n_o_out,
  output logic serr_n_oe_out,
  output logic [15:0] status_out
);

  logic [19:0] base_q;
  logic [cbb_pkg::NUM_FLAGS-1:0] flags_q;
  logic [cbb_pkg::NUM_FLAGS-1:0] flags_d;
  logic [cbb_pkg::NUM_FLAGS-1:0] set_vec;
  logic [cbb_pkg::NUM_FLAGS-1:0] clr_vec;
  logic [2:0] cserr_sync_q;
  logic cserr_act_q;
  logic serr_q;
  logic [15:0] status_word;
  logic [31:0] base_word;
  logic [31:0] rd_word;
  logic wr_base;
  logic wr_status;
  logic [7:0] lane1_byte;

  // Byte lane merge: keeps old bytes where the lane is off
  function automatic logic [7:0] lane_pick(input logic [31:0] data, input logic [3:0] be,
                                           input int lane, input logic [7:0] old);
    lane_pick = be[lane] ? data[lane*8 +: 8] : old;
  endfunction

  function automatic logic dw_write(input cbb_pkg::cbb_cfg_req_t r, input logic [5:0] dw);
    dw_write = r.valid && r.write && (r.dword == dw);
  endfunction

  assign wr_base = dw_write(cfg_req_in, cbb_pkg::CFG_DW_BASE);
  assign wr_status = dw_write(cfg_req_in, cbb_pkg::CFG_DW_STATUS);
  // Lane 1 carries base bits 15..12 in its upper nibble
  assign lane1_byte = lane_pick(cfg_req_in.wdata, cfg_req_in.be, 1, {base_q[3:0], 4'h0});

  // only the upper twenty bits store
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      base_q <= cbb_pkg::BASE_RESET;
    end else if (clk_en_in && wr_base) begin
      base_q <= {lane_pick(cfg_req_in.wdata, cfg_req_in.be, 3, base_q[19:12]),
                 lane_pick(cfg_req_in.wdata, cfg_req_in.be, 2, base_q[11:4]),
                 lane1_byte[7:4]};
    end
  end

  assign base_word = {base_q, cbb_pkg::BASE_LOW_BITS[11:4], cbb_pkg::BASE_PREFETCH,
                      cbb_pkg::BASE_TYPE_32, cbb_pkg::BASE_MEM_SPACE};
  assign base_addr_out = base_word;

  // Pin filter: change accepted once stages two and three agree
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cserr_sync_q <= 3'h7;
      cserr_act_q <= 1'b0;
    end else if (clk_en_in) begin
      cserr_sync_q <= {cserr_sync_q[1:0], cserr_n_in};
      if (cserr_sync_q[1] == cserr_sync_q[2]) begin
        cserr_act_q <= ~cserr_sync_q[2];
      end
    end
  end

  // Event sources, in flag order 15..11, 8
  always_comb begin
    set_vec[5] = evt_in.parity_det;
    set_vec[4] = cserr_act_q;
    set_vec[3] = evt_in.master_abort;
    set_vec[2] = evt_in.target_abort_rx;
    set_vec[1] = evt_in.target_abort_tx;
    set_vec[0] = evt_in.data_parity && evt_in.as_master && en_in.perr_resp_en;
  end

  always_comb begin
    clr_vec = '0;
    if (wr_status) begin
      clr_vec[5:1] = cfg_req_in.be[cbb_pkg::STATUS_LANE_HI] ? cfg_req_in.wdata[31:27] : 5'h00;
      // Bit 8 sits in the upper status byte, lane 3
      clr_vec[0] = cfg_req_in.be[cbb_pkg::STATUS_LANE_HI] & cfg_req_in.wdata[24];
    end
  end

  // Set beats a clear landing in the same cycle
  genvar g;
  generate
    for (g = 0; g < cbb_pkg::NUM_FLAGS; g++) begin : g_flag
      assign flags_d[g] = set_vec[g] | (flags_q[g] & ~clr_vec[g]);
    end
  endgenerate

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flags_q <= '0;
    end else if (clk_en_in) begin
      flags_q <= flags_d;
    end
  end

  assign status_word = {flags_q[5:1], cbb_pkg::ST_DEVSEL_MEDIUM, flags_q[0],
                        cbb_pkg::ST_FAST_B2B_VAL, cbb_pkg::ST_RSVD_VAL};
  assign status_out = status_word;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      serr_q <= 1'b0;
    end else if (clk_en_in) begin
      serr_q <= cserr_act_q && en_in.serr_en && en_in.cserr_fwd_en;
    end
  end
  assign serr_n_o_out = 1'b0;
  assign serr_n_oe_out = serr_q;

  always_comb begin
    unique case (cfg_req_in.dword)
      cbb_pkg::CFG_DW_SELF_TEST: rd_word = {cbb_pkg::SELF_TEST_VALUE, 24'h000000};
      cbb_pkg::CFG_DW_BASE: rd_word = base_word;
      cbb_pkg::CFG_DW_STATUS: rd_word = {status_word, 16'h0000};
      default: rd_word = 32'h00000000;
    endcase
  end

  // Read data one cycle after a read request
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_rdata_out <= 32'h00000000;
      cfg_rvalid_out <= 1'b0;
    end else if (clk_en_in) begin
      cfg_rvalid_out <= cfg_req_in.valid && !cfg_req_in.write;
      if (cfg_req_in.valid && !cfg_req_in.write) begin
        cfg_rdata_out <= rd_word;
      end
    end
  end

  // bit 11 splits card32 and card16
  always_comb begin
    win_out.hit = mem_valid_in && (base_q != cbb_pkg::BASE_RESET) &&
                  (mem_addr_in[31:12] == base_q);
    win_out.card16 = mem_addr_in[cbb_pkg::WIN_HALF_BIT];
    win_out.offset = mem_addr_in[10:0];
  end

endmodule

//--- src/cbb_pkg.sv
package cbb_pkg;

  // Configuration dword indices (byte offset / 4)
  localparam logic [5:0] CFG_DW_SELF_TEST = 6'h03;
  localparam logic [5:0] CFG_DW_BASE = 6'h04;
  localparam logic [5:0] CFG_DW_STATUS = 6'h05;

  // Printed byte offsets of the registers
  localparam logic [7:0] OFS_SELF_TEST = 8'h0f;
  localparam logic [7:0] OFS_BASE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h16;

  // Byte lanes inside the dword
  localparam int SELF_TEST_LANE = 3;
  localparam int STATUS_LANE_LO = 2;
  localparam int STATUS_LANE_HI = 3;

  // Socket register base address
  localparam int BASE_ADDR_LSB = 12;
  localparam int BASE_ADDR_W = 20;
  localparam logic [19:0] BASE_RESET = 20'h00000;
  localparam logic [11:0] BASE_LOW_BITS = 12'h000;
  localparam logic [0:0] BASE_PREFETCH = 1'h0;
  localparam logic [1:0] BASE_TYPE_32 = 2'h0;
  localparam logic [0:0] BASE_MEM_SPACE = 1'h0;
  localparam int BASE_PREFETCH_BIT = 3;
  localparam int BASE_TYPE_LSB = 1;
  localparam int BASE_SPACE_BIT = 0;

  // Window split: bit 11 selects the upper half
  localparam int WIN_HALF_BIT = 11;
  localparam logic [11:0] WIN_CARD32_OFS = 12'h000;
  localparam logic [11:0] WIN_CARD16_OFS = 12'h800;

  // Self-test byte value
  localparam logic [7:0] SELF_TEST_VALUE = 8'h00;

  // Secondary status bit positions
  localparam int ST_PARITY_DET = 15;
  localparam int ST_SYS_ERR = 14;
  localparam int ST_MASTER_ABORT = 13;
  localparam int ST_TARGET_ABORT_RX = 12;
  localparam int ST_TARGET_ABORT_TX = 11;
  localparam int ST_DEVSEL_LSB = 9;
  localparam int ST_DATA_PARITY = 8;
  localparam int ST_FAST_B2B = 7;
  localparam logic [1:0] ST_DEVSEL_MEDIUM = 2'h1;
  localparam logic [0:0] ST_FAST_B2B_VAL = 1'h0;
  localparam logic [6:0] ST_RSVD_VAL = 7'h00;
  localparam logic [15:0] STATUS_RESET = 16'h0200;
  localparam int NUM_FLAGS = 6;

  // Secondary bus events, one-cycle pulses from the bridge core
  typedef struct packed {
    logic parity_det;
    logic master_abort;
    logic target_abort_rx;
    logic target_abort_tx;
    logic data_parity;
    logic as_master;
  } cbb_evt_t;

  // Enable bits owned by the command and bridge control registers
  typedef struct packed {
    logic perr_resp_en;
    logic serr_en;
    logic cserr_fwd_en;
  } cbb_en_t;

  // Configuration access request
  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] dword;
    logic [3:0] be;
    logic [31:0] wdata;
  } cbb_cfg_req_t;

  // Decode result for the socket register window
  typedef struct packed {
    logic hit;
    logic card16;
    logic [10:0] offset;
  } cbb_win_t;

endpackage

//--- tb/cbb_cfg_regs_props.sv
`timescale 1ns/1ps
module cbb_cfg_regs_props (
  // Watched ports
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  input wire cbb_pkg::cbb_cfg_req_t cfg_req_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic cfg_rvalid_out,
  input wire logic mem_valid_in,
  input wire logic [31:0] mem_addr_in,
  input wire cbb_pkg::cbb_win_t win_out,
  input wire logic [31:0] base_addr_out,
  input wire cbb_pkg::cbb_evt_t evt_in,
  input wire cbb_pkg::cbb_en_t en_in,
  input wire logic cserr_n_in,
  input wire logic serr_n_o_out,
  input wire logic serr_n_oe_out,
  input wire logic [15:0] status_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  AST_SELF_TEST: assert property (
    cfg_rvalid_out && $past(clk_en_in && cfg_req_in.dword == 6'h03) |->
    cfg_rdata_out[31:24] == 8'h00) else $error("self-test not zero");
  AST_BASE_LOW: assert property (
    base_addr_out[11:0] == 12'h000) else $error("base low bits set");
  AST_NO_BASE: assert property (
    base_addr_out == 32'h0 |-> !win_out.hit) else $error("hit with zero base");
  AST_DECODE: assert property (
    mem_valid_in && base_addr_out != 32'h0 && mem_addr_in[31:12] == base_addr_out[31:12]
    |-> win_out.hit && win_out.card16 == mem_addr_in[11] && win_out.offset == mem_addr_in[10:0])
    else $error("window decode");
  AST_FIXED: assert property (
    status_out[10:9] == 2'h1 && status_out[7:0] == 8'h00) else $error("fixed status bits");
  AST_PARITY: assert property (
    clk_en_in && evt_in.parity_det |=> status_out[15]) else $error("parity flag");
  AST_ABORT: assert property (
    clk_en_in && evt_in.master_abort |=> status_out[13]) else $error("abort flag");
  AST_DPE: assert property (
    $rose(status_out[8]) |-> $past(evt_in.data_parity && evt_in.as_master && en_in.perr_resp_en))
    else $error("data parity flag");
  AST_SYS_ERR: assert property (
    (clk_en_in && !cserr_n_in) [*6] |-> status_out[14]) else $error("system error flag");
  AST_SERR: assert property (
    (clk_en_in && !cserr_n_in && en_in.serr_en && en_in.cserr_fwd_en) [*7] |->
    serr_n_oe_out && !serr_n_o_out) else $error("host error not driven");
  cover property (cfg_rvalid_out);
  cover property (win_out.hit && win_out.card16);
  cover property (serr_n_oe_out);
endmodule

//--- tb/cbb_host_model.sv
`timescale 1ns/1ps
module cbb_host_model (
  // Clock
  input wire logic clk_sys_in,
  // Config port
  output cbb_pkg::cbb_cfg_req_t req_out,
  input wire logic [31:0] rdata_in,
  input wire logic rvalid_in
);
  initial req_out = '0;
  task automatic xfer(input logic w, input logic [5:0] dw, input logic [3:0] be,
    input logic [31:0] d, output logic [31:0] q, output logic v);
    @(posedge clk_sys_in);
    req_out <= {1'b1, w, dw, be, d};
    @(posedge clk_sys_in);
    // Released lines flip so stale data cannot pass
    req_out <= {1'b0, ~req_out[42:0]};
    #1;
    q = rdata_in;
    v = rvalid_in;
  endtask
endmodule

//--- tb/cbb_cfg_regs_tb.sv
`timescale 1ns/1ps
module cbb_cfg_regs_tb;
  logic clk_sys_in = 0;
  logic arst_n_in = 0;
  logic mem_valid_in = 0;
  logic cserr_n_in = 1;
  logic clk_en_in = 1;
  logic [31:0] mem_addr_in = 0;
  logic [31:0] cfg_rdata_out, base_addr_out, rd;
  logic cfg_rvalid_out, serr_n_o_out, serr_n_oe_out, rv;
  logic [15:0] status_out;
  cbb_pkg::cbb_cfg_req_t cfg_req_in;
  cbb_pkg::cbb_evt_t evt_in = '0;
  cbb_pkg::cbb_en_t en_in = '0;
  cbb_pkg::cbb_win_t win_out;
  // Host line has a pull-up
  wire serr_n = serr_n_oe_out ? serr_n_o_out : 1'b1;
  int num_errors = 0;
  int check_count = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  cbb_cfg_regs cbb_cfg_regs_inst (.clk_sys_in, .arst_n_in, .clk_en_in, .cfg_req_in,
    .cfg_rdata_out, .cfg_rvalid_out, .mem_valid_in, .mem_addr_in, .win_out, .base_addr_out,
    .evt_in, .en_in, .cserr_n_in, .serr_n_o_out, .serr_n_oe_out, .status_out);
  cbb_host_model cbb_host_model_inst (.clk_sys_in, .req_out(cfg_req_in),
    .rdata_in(cfg_rdata_out), .rvalid_in(cfg_rvalid_out));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] d);
    cbb_host_model_inst.xfer(1'b1, dw, be, d, rd, rv);
  endtask
  task automatic rdw(input logic [5:0] dw);
    cbb_host_model_inst.xfer(1'b0, dw, 4'hf, 32'h0, rd, rv);
    chk({31'h0, rv}, 32'h1);
  endtask
  task automatic sts(input logic [15:0] e);
    rdw(6'h05);
    chk({16'h0, rd[31:16]}, {16'h0, e});
  endtask
  task automatic win(input logic [31:0] a, input logic [12:0] e);
    @(posedge clk_sys_in);
    mem_addr_in <= a;
    mem_valid_in <= 1'b1;
    #1;
    chk({19'h0, win_out}, {19'h0, e});
  endtask
  task automatic pulse(input logic [5:0] e, input logic [2:0] n);
    @(posedge clk_sys_in);
    evt_in <= e;
    en_in <= n;
    @(posedge clk_sys_in);
    evt_in <= '0;
  endtask
  task automatic pin(input logic lvl, input logic [2:0] n, input logic e);
    @(posedge clk_sys_in);
    cserr_n_in <= lvl;
    en_in <= n;
    repeat (7) @(posedge clk_sys_in);
    #1;
    chk({31'h0, serr_n}, {31'h0, e});
  endtask
  task automatic t_regs;
    sts(16'h0200);
    win(32'h0, 13'h0);
    wr(6'h03, 4'h8, 32'hffffffff);
    rdw(6'h03);
    chk(rd & 32'hff000000, 32'h0);
    wr(6'h04, 4'hf, 32'hffffffff);
    rdw(6'h04);
    chk(rd, 32'hfffff000);
    wr(6'h04, 4'hf, 32'h1234500f);
    win(32'h12345804, 13'h1804);
    win(32'h12345010, 13'h1010);
    win(32'h12346000, 13'h0);
    $display("t_regs end");
  endtask
  task automatic t_events;
    pulse(6'h20, 3'h0);
    pulse(6'h03, 3'h0);
    sts(16'h8200);
    pulse(6'h02, 3'h4);
    sts(16'h8200);
    pulse(6'h03, 3'h4);
    pulse(6'h1c, 3'h4);
    sts(16'hbb00);
    wr(6'h05, 4'hc, 32'h0);
    sts(16'hbb00);
    wr(6'h05, 4'hc, 32'h20000000);
    sts(16'h9b00);
    wr(6'h05, 4'hc, 32'hffff0000);
    sts(16'h0200);
    $display("t_events end");
  endtask
  task automatic t_cserr;
    pin(1'b0, 3'h3, 1'b0);
    pin(1'b1, 3'h3, 1'b1);
    pin(1'b0, 3'h0, 1'b1);
    pin(1'b1, 3'h0, 1'b1);
    sts(16'h4200);
    $display("t_cserr end");
  endtask
  task automatic t_freeze;
    @(posedge clk_sys_in);
    clk_en_in <= 1'b0;
    evt_in <= 6'h10;
    @(posedge clk_sys_in);
    evt_in <= '0;
    clk_en_in <= 1'b1;
    sts(16'h4200);
    rdw(6'h06);
    chk(rd, 32'h0);
    $display("t_freeze end");
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    t_regs;
    t_events;
    t_cserr;
    t_freeze;
    test_done;
  end
  initial begin
    #20000;
    num_errors++;
    test_done;
  end
endmodule
bind cbb_cfg_regs cbb_cfg_regs_props cbb_cfg_regs_props_inst (.clk_sys_in, .arst_n_in,
  .clk_en_in, .cfg_req_in, .cfg_rdata_out, .cfg_rvalid_out, .mem_valid_in, .mem_addr_in,
  .win_out, .base_addr_out, .evt_in, .en_in, .cserr_n_in, .serr_n_o_out, .serr_n_oe_out,
  .status_out);
